/* File: logic/bcd_conv_pkg.sv */
package bcd_conv_pkg;

	localparam int          WORD_W       = 32;
	localparam int          NIBBLE_W     = 4;
	localparam int          DIGITS       = 8;
	localparam int          MAG_DIGITS   = 7;
	localparam int          MAG_W        = 24;
	localparam int          BCD_W        = MAG_DIGITS * NIBBLE_W;

	// integer reading of the all-nines BCD word, 161061273
	localparam logic [31:0] BCD_POS_LIMIT = 32'h0999_9999;
	// integer reading of the negative limit word, -161061273
	localparam logic [31:0] BCD_NEG_LIMIT = 32'hF666_6667;
	// 9999999 and -9999999
	localparam logic [31:0] BIN_POS_LIMIT = 32'h0098_967F;
	localparam logic [31:0] BIN_NEG_LIMIT = 32'hFF67_6981;

	localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
	localparam logic [31:0] DEC_RADIX     = 32'h0000_000A;
	localparam logic [3:0]  DIGIT_MAX     = 4'h9;
	localparam logic [3:0]  DABBLE_MIN    = 4'h5;
	localparam logic [3:0]  DABBLE_ADD    = 4'h3;
	localparam logic [3:0]  NEG_NIBBLE    = 4'hF;
	localparam logic [3:0]  ZERO_NIBBLE   = 4'h0;
	localparam logic [31:0] SMALL_BIN_MAX = 32'h0000_0063;

	typedef enum logic {
		MODE_BCD,
		MODE_BIN
	} conv_mode_type;

	typedef struct packed {
		conv_mode_type      mode;
		logic [WORD_W-1:0]  word;
	} conv_req_type;

	typedef struct packed {
		logic [WORD_W-1:0]  word;
		logic               saturated;
	} conv_res_type;

	typedef struct packed {
		logic [WORD_W-1:0]  word;
		logic               saturated;
		logic               update;
	} conv_state_type;

endpackage : bcd_conv_pkg

/* File: logic/radix_core.sv */
`timescale 1ns/1ps
module radix_core
	import bcd_conv_pkg::*;
(
	input  conv_req_type req,
	output conv_res_type res
);

	logic signed [WORD_W-1:0] src_s;
	logic        [WORD_W-1:0] pattern;
	logic        [WORD_W-1:0] acc;
	logic        [WORD_W-1:0] mag;
	logic        [BCD_W-1:0]  bcd;
	logic        [WORD_W-1:0] bcd_word;

	assign src_s = $signed(req.word);

	always_comb begin
		pattern   = RESET_WORD;
		acc       = RESET_WORD;
		mag       = RESET_WORD;
		bcd       = '0;
		bcd_word  = RESET_WORD;
		res.word  = RESET_WORD;
		res.saturated = 1'b0;
		if (req.mode == MODE_BCD) begin
			if (src_s > $signed(BCD_POS_LIMIT)) begin
				res.word      = BIN_POS_LIMIT;
				res.saturated = 1'b1;
			end else if (src_s < $signed(BCD_NEG_LIMIT)) begin
				res.word      = BIN_NEG_LIMIT;
				res.saturated = 1'b1;
			end else begin
				// negative words are the two's complement of the digits
				pattern = req.word[WORD_W-1] ? -req.word : req.word;
				for (int i = DIGITS - 1; i >= 0; i--) begin
					acc = acc * DEC_RADIX
						+ {28'h0000000, pattern[i*NIBBLE_W +: NIBBLE_W]};
				end
				res.word = req.word[WORD_W-1] ? -acc : acc;
			end
		end else begin
			if (src_s > $signed(BIN_POS_LIMIT)) begin
				res.word      = BCD_POS_LIMIT;
				res.saturated = 1'b1;
			end else if (src_s < $signed(BIN_NEG_LIMIT)) begin
				res.word      = BCD_NEG_LIMIT;
				res.saturated = 1'b1;
			end else begin
				mag = req.word[WORD_W-1] ? -req.word : req.word;
				// shift-add-three over the magnitude bits
				for (int b = MAG_W - 1; b >= 0; b--) begin
					for (int d = 0; d < MAG_DIGITS; d++) begin
						if (bcd[d*NIBBLE_W +: NIBBLE_W] >= DABBLE_MIN) begin
							bcd[d*NIBBLE_W +: NIBBLE_W] =
								bcd[d*NIBBLE_W +: NIBBLE_W] + DABBLE_ADD;
						end
					end
					bcd = {bcd[BCD_W-2:0], mag[b]};
				end
				bcd_word = {ZERO_NIBBLE, bcd};
				res.word = req.word[WORD_W-1] ? -bcd_word : bcd_word;
			end
		end
	end

endmodule : radix_core

/* File: logic/bcd_binary_converter.sv */
`timescale 1ns/1ps
module bcd_binary_converter
	import bcd_conv_pkg::*;
#(
	parameter bit RELEASE_BY_ENABLE = 1'b1
) (
	input  wire logic              clk_sys,
	input  wire logic              arst_n,
	input  wire conv_mode_type     mode_sel,
	input  wire logic              enable_in,
	input  wire logic [WORD_W-1:0] source_word_in,
	output logic      [WORD_W-1:0] converted_word_out,
	output logic                   saturated_out,
	output logic                   update_out
);

	conv_state_type state_q;
	conv_state_type state_d;
	conv_req_type   core_req;
	conv_res_type   core_res;
	logic           run;

	assign core_req.mode = mode_sel;
	assign core_req.word = source_word_in;

	radix_core u_core (
		.req (core_req),
		.res (core_res)
	);

	// enable honoured only when the release parameter is set
	assign run = !RELEASE_BY_ENABLE || enable_in;

	always_comb begin
		state_d        = state_q;
		state_d.update = 1'b0;
		if (run) begin
			state_d.word      = core_res.word;
			state_d.saturated = core_res.saturated;
			state_d.update    = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q.word      <= RESET_WORD;
			state_q.saturated <= 1'b0;
			state_q.update    <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	assign converted_word_out = state_q.word;
	assign saturated_out      = state_q.saturated;
	assign update_out         = state_q.update;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	a_bcd_pos_sat: assert property (
		run && mode_sel == MODE_BCD
			&& $signed(source_word_in) > $signed(BCD_POS_LIMIT)
		|=> converted_word_out == BIN_POS_LIMIT && saturated_out
	) else $error("bcd mode positive saturation wrong");

	a_bcd_neg_sat: assert property (
		run && mode_sel == MODE_BCD
			&& $signed(source_word_in) < $signed(BCD_NEG_LIMIT)
		|=> converted_word_out == BIN_NEG_LIMIT && saturated_out
	) else $error("bcd mode negative saturation wrong");

	a_bin_pos_sat: assert property (
		run && mode_sel == MODE_BIN
			&& $signed(source_word_in) > $signed(BIN_POS_LIMIT)
		|=> converted_word_out == BCD_POS_LIMIT && saturated_out
	) else $error("bin mode positive saturation wrong");

	a_bin_neg_sat: assert property (
		run && mode_sel == MODE_BIN
			&& $signed(source_word_in) < $signed(BIN_NEG_LIMIT)
		|=> converted_word_out == BCD_NEG_LIMIT && saturated_out
	) else $error("bin mode negative saturation wrong");

	a_bcd_two_digit: assert property (
		run && mode_sel == MODE_BCD
			&& source_word_in[WORD_W-1:2*NIBBLE_W] == '0
			&& source_word_in[7:4] <= DIGIT_MAX
			&& source_word_in[3:0] <= DIGIT_MAX
		|=> converted_word_out
			== $past(source_word_in[7:4]) * DEC_RADIX
			+ {28'h0000000, $past(source_word_in[3:0])}
			&& !saturated_out
	) else $error("two digit bcd decode wrong");

	a_bin_two_digit: assert property (
		run && mode_sel == MODE_BIN
			&& source_word_in <= SMALL_BIN_MAX
		|=> converted_word_out[7:4]
			== 4'($past(source_word_in) / DEC_RADIX)
			&& converted_word_out[3:0]
			== 4'($past(source_word_in) % DEC_RADIX)
			&& converted_word_out[WORD_W-1:2*NIBBLE_W] == '0
	) else $error("two digit bin encode wrong");

	a_bcd_neg_sign: assert property (
		run && mode_sel == MODE_BCD && source_word_in[WORD_W-1]
			&& $signed(source_word_in) >= $signed(BCD_NEG_LIMIT)
			&& source_word_in[WORD_W-1:NIBBLE_W] != 28'hFFFFFFF
		|=> converted_word_out[WORD_W-1]
	) else $error("negative bcd word not negative");

	a_bin_neg_sign: assert property (
		run && mode_sel == MODE_BIN && source_word_in[WORD_W-1]
			&& $signed(source_word_in) >= $signed(BIN_NEG_LIMIT)
		|=> converted_word_out[WORD_W-1 -: NIBBLE_W] == NEG_NIBBLE
	) else $error("negative bin result lacks sign nibble");

	a_bin_range: assert property (
		run && mode_sel == MODE_BIN
		|=> $signed(converted_word_out) <= $signed(BCD_POS_LIMIT)
			&& $signed(converted_word_out) >= $signed(BCD_NEG_LIMIT)
	) else $error("bin result outside decimal range");

	a_bcd_range: assert property (
		run && mode_sel == MODE_BCD
		|=> $signed(converted_word_out) <= $signed(BIN_POS_LIMIT)
			&& $signed(converted_word_out) >= $signed(BIN_NEG_LIMIT)
	) else $error("bcd result outside decimal range");

	a_hold_disabled: assert property (
		RELEASE_BY_ENABLE && !enable_in
		|=> $stable(converted_word_out) && $stable(saturated_out)
			&& !update_out
	) else $error("output moved while disabled");

	a_update_each: assert property (
		run ##1 run
		|=> update_out && $past(update_out)
			&& converted_word_out == $past(core_res.word)
	) else $error("output not updated while enabled");

	a_reset_clear: assert property (
		disable iff (1'b0)
		$rose(arst_n)
		|-> converted_word_out == RESET_WORD
			&& !saturated_out && !update_out
	) else $error("outputs not cleared by reset");

	a_free_running: assert property (
		!RELEASE_BY_ENABLE
		|=> update_out
	) else $error("free running copy skipped a cycle");

	a_bin_no_sat: assert property (
		run && mode_sel == MODE_BIN
			&& $signed(source_word_in) <= $signed(BIN_POS_LIMIT)
			&& $signed(source_word_in) >= $signed(BIN_NEG_LIMIT)
		|=> !saturated_out
	) else $error("in range bin word flagged saturated");

	a_bcd_no_sat: assert property (
		run && mode_sel == MODE_BCD
			&& $signed(source_word_in) <= $signed(BCD_POS_LIMIT)
			&& $signed(source_word_in) >= $signed(BCD_NEG_LIMIT)
		|=> !saturated_out
	) else $error("in range bcd word flagged saturated");

	a_bin_digits: assert property (
		run && mode_sel == MODE_BIN && !source_word_in[WORD_W-1]
			&& $signed(source_word_in) <= $signed(BIN_POS_LIMIT)
		|=> converted_word_out[31:28] == ZERO_NIBBLE
			&& converted_word_out[27:24] <= DIGIT_MAX
			&& converted_word_out[23:20] <= DIGIT_MAX
			&& converted_word_out[19:16] <= DIGIT_MAX
			&& converted_word_out[15:12] <= DIGIT_MAX
			&& converted_word_out[11:8] <= DIGIT_MAX
			&& converted_word_out[7:4] <= DIGIT_MAX
			&& converted_word_out[3:0] <= DIGIT_MAX
	) else $error("bin result holds a non decimal digit");

	a_bin_zero: assert property (
		run && mode_sel == MODE_BIN && source_word_in == RESET_WORD
		|=> converted_word_out == RESET_WORD
	) else $error("bin zero not encoded as zero");

	a_bcd_zero: assert property (
		run && mode_sel == MODE_BCD && source_word_in == RESET_WORD
		|=> converted_word_out == RESET_WORD
	) else $error("bcd zero not decoded as zero");

	a_bcd_pos_sign: assert property (
		run && mode_sel == MODE_BCD && !source_word_in[WORD_W-1]
		|=> !converted_word_out[WORD_W-1]
	) else $error("positive bcd word gave negative result");

	a_bcd_top_edge: assert property (
		run && mode_sel == MODE_BCD && source_word_in == BCD_POS_LIMIT
		|=> converted_word_out == BIN_POS_LIMIT && !saturated_out
	) else $error("largest bcd word not decoded");

	a_bcd_low_edge: assert property (
		run && mode_sel == MODE_BCD && source_word_in == BCD_NEG_LIMIT
		|=> converted_word_out == BIN_NEG_LIMIT && !saturated_out
	) else $error("smallest bcd word not decoded");

	a_bin_top_edge: assert property (
		run && mode_sel == MODE_BIN && source_word_in == BIN_POS_LIMIT
		|=> converted_word_out == BCD_POS_LIMIT && !saturated_out
	) else $error("largest bin value not encoded");

	a_bin_low_edge: assert property (
		run && mode_sel == MODE_BIN && source_word_in == BIN_NEG_LIMIT
		|=> converted_word_out == BCD_NEG_LIMIT && !saturated_out
	) else $error("smallest bin value not encoded");

endmodule : bcd_binary_converter

/* File: verif/bcd_binary_converter_bench.sv */
`timescale 1ns/1ps
module bcd_binary_converter_bench;
	import bcd_conv_pkg::*;

	logic              clk_sys;
	logic              arst_n;
	conv_mode_type     mode_sel;
	logic              enable_in;
	logic [WORD_W-1:0] source_word_in;
	logic [WORD_W-1:0] converted_word_out;
	logic              saturated_out;
	logic              update_out;
	logic [WORD_W-1:0] free_word_out;
	int                fail_count;
	int                num_checks;
	int                cycle_count;

	bcd_binary_converter #(.RELEASE_BY_ENABLE(1'b1)) dut_u (
		.clk_sys            (clk_sys),
		.arst_n             (arst_n),
		.mode_sel           (mode_sel),
		.enable_in          (enable_in),
		.source_word_in     (source_word_in),
		.converted_word_out (converted_word_out),
		.saturated_out      (saturated_out),
		.update_out         (update_out)
	);

	// free-running copy, enable ignored
	bcd_binary_converter #(.RELEASE_BY_ENABLE(1'b0)) dut_free_u (
		.clk_sys            (clk_sys),
		.arst_n             (arst_n),
		.mode_sel           (mode_sel),
		.enable_in          (enable_in),
		.source_word_in     (source_word_in),
		.converted_word_out (free_word_out),
		.saturated_out      (),
		.update_out         ()
	);

	task final_report;
		if (fail_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	task check_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_word

	task check_flag(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_flag

	// drive at one edge, look after the taking edge
	task apply(input conv_mode_type m, input logic [31:0] w, input logic en);
		@(posedge clk_sys);
		mode_sel       <= m;
		source_word_in <= w;
		enable_in      <= en;
		@(posedge clk_sys);
		#1;
	endtask : apply

	task conv(input conv_mode_type m, input logic [31:0] w,
		input logic [31:0] exp, input logic sat);
		apply(m, w, 1'b1);
		check_word(converted_word_out, exp);
		check_flag(saturated_out, sat);
		check_flag(update_out, 1'b1);
	endtask : conv

	task test_reset;
		check_word(converted_word_out, RESET_WORD);
		check_flag(update_out, 1'b0);
	endtask : test_reset

	task test_bcd_plain;
		conv(MODE_BCD, 32'h0000_0025, 32'h0000_0019, 1'b0);
		conv(MODE_BCD, 32'h0000_4899, 32'h0000_1323, 1'b0);
		conv(MODE_BCD, 32'h0999_9999, 32'h0098_967F, 1'b0);
		conv(MODE_BCD, 32'hF666_6667, 32'hFF67_6981, 1'b0);
	endtask : test_bcd_plain

	task test_bcd_sat;
		conv(MODE_BCD, 32'h0999_999A, 32'h0098_967F, 1'b1);
		conv(MODE_BCD, 32'h7FFF_FFFF, 32'h0098_967F, 1'b1);
		conv(MODE_BCD, 32'hF666_6666, 32'hFF67_6981, 1'b1);
		conv(MODE_BCD, 32'h9999_9999, 32'hFF67_6981, 1'b1);
	endtask : test_bcd_sat

	task test_bin_plain;
		conv(MODE_BIN, 32'h0000_0017, 32'h0000_0023, 1'b0);
		conv(MODE_BIN, 32'h0000_0000, 32'h0000_0000, 1'b0);
		conv(MODE_BIN, 32'h0098_967F, 32'h0999_9999, 1'b0);
		conv(MODE_BIN, 32'hFF67_6981, 32'hF666_6667, 1'b0);
	endtask : test_bin_plain

	task test_bin_sat;
		conv(MODE_BIN, 32'h0098_9680, 32'h0999_9999, 1'b1);
		conv(MODE_BIN, 32'hFF67_6980, 32'hF666_6667, 1'b1);
		conv(MODE_BIN, 32'h8000_0000, 32'hF666_6667, 1'b1);
	endtask : test_bin_sat

	task test_enable;
		conv(MODE_BIN, 32'h0000_0025, 32'h0000_0037, 1'b0);
		apply(MODE_BIN, 32'h0000_0009, 1'b0);
		check_word(converted_word_out, 32'h0000_0037);
		check_flag(update_out, 1'b0);
		check_word(free_word_out, 32'h0000_0009);
		apply(MODE_BCD, 32'h0000_0099, 1'b0);
		check_word(converted_word_out, 32'h0000_0037);
		check_word(free_word_out, 32'h0000_0063);
		conv(MODE_BCD, 32'h0000_0099, 32'h0000_0063, 1'b0);
	endtask : test_enable

	initial begin
		clk_sys = 1'b0;
		forever begin
			#2.5 clk_sys = ~clk_sys;
		end
	end

	// hang guard
	always @(posedge clk_sys) begin
		cycle_count++;
		if (cycle_count == 2000) begin
			fail_count++;
			final_report();
		end
	end

	initial begin
		fail_count     = 0;
		num_checks     = 0;
		cycle_count    = 0;
		arst_n         = 1'b0;
		mode_sel       = MODE_BCD;
		enable_in      = 1'b0;
		source_word_in = 32'h0000_0000;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		test_reset();
		test_bcd_plain();
		test_bcd_sat();
		test_bin_plain();
		test_bin_sat();
		test_enable();
		final_report();
	end

endmodule : bcd_binary_converter_bench
